/* File: i2c_host_model.sv */
// ****************************************
// host controller on the serial bus
// ****************************************
module i2c_host_model (
  input  wire logic mclk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock parks high between frames, data released
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // one bit: data moves mid low phase, sampled late in high
  task automatic bit_io(input logic d, output logic q);
    tick(2);
    sda_oe_out <= ~d;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    q = sda_in;
    scl_out <= 1'b0;
  endtask
  // start or repeated start: release data, raise clock, then pull data low
  task automatic start();
    tick(4);
    sda_oe_out <= 1'b0;
    tick(4);
    scl_out <= 1'b1;
    tick(4);
    sda_oe_out <= 1'b1;
    tick(4);
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_oe_out <= 1'b1;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_oe_out <= 1'b0;
    tick(4);
  endtask
  // byte out msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      q[i] = b;
    end
    bit_io(last, b);
    ack = ~b;
  endtask
  task automatic access(input logic [6:0] a, input logic [7:0] p,
                        input logic rd, input int n,
                        ref logic [7:0] dq [$], output logic ok);
    logic [7:0] q;
    logic       ack;
    start();
    xfer({a, 1'b0}, 1'b1, q, ok);
    xfer(p, 1'b1, q, ack);
    ok &= ack;
    if (rd) begin
      start();
      xfer({a, 1'b1}, 1'b1, q, ack);
      ok &= ack;
      for (int i = 0; i < n; i++) begin
        xfer(8'hFF, i == n - 1, q, ack);
        dq.push_back(q);
      end
    end else begin
      foreach (dq[i]) begin
        xfer(dq[i], 1'b1, q, ack);
        ok &= ack;
      end
    end
    stop();
  endtask
endmodule

/* File: load_channel_seq.sv */
`include "load_switch_defs.svh"
module load_channel_seq #(
  parameter int unsigned SS_BASE_CYC = `CYC_MIN(`SS_BASE_NS),
  parameter int unsigned DIS_CYC     = `CYC_MIN(`DIS_PULSE_NS)
) (
  input  wire logic                      mclk_in,
  input  wire logic                      rstn_in,
  input  wire logic                      lockout_in,
  input  wire logic                      chan_on_in,
  input  wire load_switch_pkg::chan_cfg_t cfg_in,
  output load_switch_pkg::chan_drv_t      drv_out
);
  import load_switch_pkg::*;

  localparam logic [18:0] OFF_CYC = 19'(`CYC_MIN(`OFF_TO_DIS_NS));
  localparam logic [18:0] BBM_CYC = 19'(`CYC_MIN(`BBM_NS));

  chan_state_t state_reg;   // sequencer state
  logic [18:0] cnt_reg;     // cycles left in timed state

  // ramp length: base doubled per select step
  function automatic logic [18:0] ramp_len(input logic [1:0] sel);
    ramp_len = 19'(SS_BASE_CYC) << sel;
  endfunction

  // ************************************************
  // sequencer
  // ************************************************
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= CH_OFF;
      cnt_reg   <= 19'h00000;
    end else if (lockout_in) begin
      state_reg <= CH_OFF;
      cnt_reg   <= 19'h00000;
    end else begin
      if (cnt_reg != 19'h00000) cnt_reg <= cnt_reg - 19'h00001;
      case (state_reg)
        CH_OFF: begin
          if (chan_on_in) begin
            state_reg <= CH_BBM;
            cnt_reg   <= BBM_CYC - 19'h00001;
          end
        end
        CH_RAMP, CH_ON: begin
          if (!chan_on_in) begin
            state_reg <= CH_OFF_DLY;
            cnt_reg   <= OFF_CYC - 19'h00001;
          end else if (state_reg == CH_RAMP && cnt_reg == 19'h00000) begin
            state_reg <= CH_ON;
          end
        end
        CH_OFF_DLY: begin
          if (chan_on_in) begin
            state_reg <= CH_BBM;
            cnt_reg   <= BBM_CYC - 19'h00001;
          end else if (cnt_reg == 19'h00000) begin
            if (cfg_in.dischg_allow) begin
              state_reg <= CH_DIS;
              cnt_reg   <= 19'(DIS_CYC) - 19'h00001;
            end else begin
              state_reg <= CH_OFF;
            end
          end
        end
        CH_DIS: begin
          if (chan_on_in) begin
            state_reg <= CH_BBM;
            cnt_reg   <= BBM_CYC - 19'h00001;
          end else if (!cfg_in.dischg_allow) begin
            state_reg <= CH_OFF;
          end else if (!cfg_in.dischg_hold_type && cnt_reg == 19'h00000) begin
            state_reg <= CH_OFF;
          end else if (cfg_in.dischg_hold_type) begin
            cnt_reg <= cnt_reg;
          end
        end
        CH_BBM: begin
          if (!chan_on_in) begin
            state_reg <= CH_OFF;
          end else if (cnt_reg == 19'h00000) begin
            if (cfg_in.softstart_use) begin
              state_reg <= CH_RAMP;
              cnt_reg   <= ramp_len({cfg_in.softstart_sel_hi,
                                     cfg_in.softstart_sel_lo}) - 19'h00001;
            end else begin
              state_reg <= CH_ON;
            end
          end
        end
        default: state_reg <= CH_OFF;
      endcase
    end
  end

  assign drv_out.main_on   = (state_reg == CH_RAMP) || (state_reg == CH_ON);
  assign drv_out.dischg_on = (state_reg == CH_DIS);
  assign drv_out.ramp_on   = (state_reg == CH_RAMP);

  // ************************************************
  // checks
  // ************************************************
  // least main-off to discharge-on gap in cycles
  localparam logic [4:0] GAP_MIN = 5'(`CYC_MIN(`OFF_TO_DIS_NS));

  logic [4:0] off_gap_reg;  // cycles since main switch was last on

  // helper count of main-off cycles, saturating
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      off_gap_reg <= 5'h1F;
    end else if (drv_out.main_on) begin
      off_gap_reg <= 5'h00;
    end else if (off_gap_reg != 5'h1F) begin
      off_gap_reg <= off_gap_reg + 5'h01;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  AST_NO_OVERLAP: assert property (!(drv_out.main_on && drv_out.dischg_on))
    else $error("main and discharge on together");
  AST_OFF_GAP: assert property (
    $rose(drv_out.dischg_on) |-> off_gap_reg >= GAP_MIN)
    else $error("discharge too soon after main off");
  AST_BBM_GAP: assert property ($fell(drv_out.dischg_on) |-> !drv_out.main_on [*5])
    else $error("main on too soon after discharge");
  AST_DIS_START: assert property (
    $fell(drv_out.main_on) && !$past(lockout_in) && cfg_in.dischg_allow
    |-> ##[1:11] (drv_out.dischg_on || chan_on_in || lockout_in
                  || !cfg_in.dischg_allow))
    else $error("discharge did not start after main off");
  AST_DIS_DENY: assert property (state_reg == CH_OFF_DLY && cnt_reg == 19'h00000 && !chan_on_in && !cfg_in.dischg_allow && !lockout_in |=> state_reg == CH_OFF)
    else $error("discharge started while not allowed");
  AST_NO_RAMP: assert property (state_reg == CH_BBM && cnt_reg == 19'h00000 && chan_on_in && !lockout_in && !cfg_in.softstart_use |=> drv_out.main_on && !drv_out.ramp_on)
    else $error("ramp used while soft start off");
  AST_PULSE_MIN: assert property ($rose(drv_out.dischg_on) && !cfg_in.dischg_hold_type |-> drv_out.dischg_on [*8] or ##[1:8] (chan_on_in || lockout_in || !cfg_in.dischg_allow))
    else $error("discharge pulse cut short");
  AST_HOLD: assert property (drv_out.dischg_on && cfg_in.dischg_hold_type && cfg_in.dischg_allow && !chan_on_in && !lockout_in |=> drv_out.dischg_on)
    else $error("held discharge dropped");
  AST_REON: assert property (drv_out.dischg_on && chan_on_in |=> !drv_out.dischg_on)
    else $error("discharge not ended on turn on");
  AST_LOCK: assert property (lockout_in |=> !drv_out.main_on && !drv_out.dischg_on)
    else $error("drive active under lockout");
  COV_RAMP: cover property ($rose(drv_out.ramp_on));
  COV_REON: cover property (drv_out.dischg_on ##1 state_reg == CH_BBM);
  COV_HOLD: cover property (drv_out.dischg_on && cfg_in.dischg_hold_type);
endmodule

/* File: load_switch_ctrl_regs.sv */
// Summary of operation
// - answer at seven-bit target address 0x2E
// - register 0x05 holds channel on bits
// - channel 0 on from bit or pin
// - soft start off means instant turn on
// - select field picks 1, 2, 4, 8 ms
// - discharge disallowed means no discharge
// - pulse discharge lasts at least 1.7 ms
// - held discharge lasts while channel off
// - discharge starts when main switch turns off
// - main and discharge never on together
// - turn on ends discharge, then delay
// - discharge off to main on 100 ns
// - main off to discharge on 220 ns
// - lockout forces off and resets registers
// - enable pin low ignores commands, freezes
// - pointer advances after each data byte
// - pointer never wraps back to zero
`include "load_switch_defs.svh"
module load_switch_ctrl_regs #(
  parameter int unsigned SS_BASE_CYC = `CYC_MIN(`SS_BASE_NS),
  parameter int unsigned DIS_CYC     = `CYC_MIN(`DIS_PULSE_NS)
) (
  input  wire logic       mclk_in,
  input  wire logic       rstn_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output wire logic       sda_out,
  output wire logic       sda_oe_out,
  input  wire logic       i2c_enable_in,
  input  wire logic       chan0_force_pin_in,
  input  wire logic       supply_undervolt_lockout_in,
  output wire logic [4:0] main_sw_on_out,
  output wire logic [4:0] dischg_on_out,
  output wire logic [4:0] ramp_on_out
);
  import load_switch_pkg::*;

  // ************************************************
  // input synchronisers
  // ************************************************
  logic [4:0] sync1_reg;   // first stage, read only by second
  logic [4:0] sync2_reg;   // second stage, safe to use
  logic [1:0] line_d_reg;  // previous scl and sda levels
  logic       scl_s;       // synced clock line
  logic       sda_s;       // synced data line
  logic       i2cen_s;     // synced enable pin
  logic       force_s;     // synced channel 0 force pin
  logic       lock_s;      // synced lockout

  // two flops on every pin
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_reg <= 5'h03;
      sync2_reg <= 5'h03;
    end else begin
      sync1_reg <= {supply_undervolt_lockout_in, chan0_force_pin_in,
                    i2c_enable_in, sda_in, scl_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign scl_s   = sync2_reg[0];
  assign sda_s   = sync2_reg[1];
  assign i2cen_s = sync2_reg[2];
  assign force_s = sync2_reg[3];
  assign lock_s  = sync2_reg[4];

  // line history for edge and condition detection
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_d_reg <= 2'h3;
    end else begin
      line_d_reg <= {sda_s, scl_s};
    end
  end

  logic scl_rise;   // clock line rose
  logic scl_fall;   // clock line fell
  logic start_det;  // data fell while clock high
  logic stop_det;   // data rose while clock high

  assign scl_rise  = scl_s & ~line_d_reg[0];
  assign scl_fall  = ~scl_s & line_d_reg[0];
  assign start_det = scl_s & line_d_reg[0] & line_d_reg[1] & ~sda_s;
  assign stop_det  = scl_s & line_d_reg[0] & ~line_d_reg[1] & sda_s;

  // ************************************************
  // register storage
  // ************************************************
  logic [4:0] setup_reg [`CHAN_COUNT];  // channel setup registers
  logic [4:0] on_bits_reg;              // channel on bits
  logic [4:0] eff_en_reg;               // on requests seen by channels

  // ************************************************
  // serial target
  // ************************************************
  i2c_state_t i2c_state_reg;  // byte level state
  logic [7:0] shift_reg;      // receive and send shifter
  logic [3:0] bit_cnt_reg;    // bits moved in current byte
  logic       first_reg;      // next byte is the address byte
  logic       rw_reg;         // high for a read transfer
  logic       ptr_set_reg;    // pointer byte already taken
  logic [7:0] ptr_reg;        // register pointer
  logic       nack_reg;       // host refused further bytes
  logic       sda_oe_reg;     // pull data line low
  logic [7:0] rd_data;        // byte at the pointer
  logic       wr_stb;         // one-cycle register write
  logic       byte_end;       // eighth bit finished

  // pointer advance that sticks at the top
  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    ptr_inc = (p == `PTR_MAX) ? p : p + 8'h01;
  endfunction

  // mapped setup register offset
  function automatic logic is_setup(input logic [7:0] p);
    is_setup = (p <= `OFS_SETUP_LAST);
  endfunction

  // read mux, unmapped reads return zero
  always_comb begin
    rd_data = 8'h00;
    if (is_setup(ptr_reg)) begin
      rd_data = {3'h0, setup_reg[ptr_reg[2:0]]};
    end else if (ptr_reg == `OFS_ON_BITS) begin
      rd_data = {3'h0, on_bits_reg};
    end
  end

  assign byte_end = (i2c_state_reg == I2C_RX) && scl_fall
                    && (bit_cnt_reg == 4'h8);
  assign wr_stb = byte_end && !first_reg && !rw_reg && ptr_set_reg
                  && i2cen_s && !lock_s;

  // byte level protocol engine
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      i2c_state_reg <= I2C_IDLE;
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 4'h0;
      first_reg     <= 1'b0;
      rw_reg        <= 1'b0;
      ptr_set_reg   <= 1'b0;
      ptr_reg       <= 8'h00;
      nack_reg      <= 1'b0;
      sda_oe_reg    <= 1'b0;
    end else if (lock_s) begin
      // lockout returns pointer to power-up value
      i2c_state_reg <= I2C_IDLE;
      ptr_reg       <= 8'h00;
      ptr_set_reg   <= 1'b0;
      sda_oe_reg    <= 1'b0;
    end else if (stop_det) begin
      // stop releases the bus
      i2c_state_reg <= I2C_IDLE;
      sda_oe_reg    <= 1'b0;
    end else if (start_det) begin
      // start or repeated start begins an address byte
      i2c_state_reg <= I2C_RX;
      bit_cnt_reg   <= 4'h0;
      first_reg     <= 1'b1;
      sda_oe_reg    <= 1'b0;
    end else begin
      case (i2c_state_reg)
        I2C_RX: begin
          if (scl_rise && bit_cnt_reg != 4'h8) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            bit_cnt_reg <= 4'h0;
            first_reg   <= 1'b0;
            nack_reg    <= 1'b0;
            if (first_reg) begin
              if (shift_reg[7:1] == `TARGET_ADDR7 && i2cen_s) begin
                i2c_state_reg <= I2C_ACK;
                sda_oe_reg    <= 1'b1;
                rw_reg        <= shift_reg[0];
                ptr_set_reg   <= 1'b0;
              end else begin
                i2c_state_reg <= I2C_IDLE;
              end
            end else begin
              i2c_state_reg <= I2C_ACK;
              sda_oe_reg    <= 1'b1;
              // first written byte is the pointer
              if (!ptr_set_reg) begin
                ptr_reg     <= shift_reg;
                ptr_set_reg <= 1'b1;
              end else begin
                ptr_reg <= ptr_inc(ptr_reg);
              end
            end
          end
        end
        I2C_ACK, I2C_RACK: begin
          if (i2c_state_reg == I2C_RACK && scl_rise) begin
            nack_reg <= sda_s;
          end else if (scl_fall) begin
            if (rw_reg && !nack_reg) begin
              // load next read byte, advance
              i2c_state_reg <= I2C_TX;
              shift_reg     <= rd_data;
              sda_oe_reg    <= ~rd_data[7];
              bit_cnt_reg   <= 4'h1;
              ptr_reg       <= ptr_inc(ptr_reg);
            end else if (rw_reg) begin
              i2c_state_reg <= I2C_IDLE;
              sda_oe_reg    <= 1'b0;
            end else begin
              i2c_state_reg <= I2C_RX;
              sda_oe_reg    <= 1'b0;
            end
          end
        end
        I2C_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              i2c_state_reg <= I2C_RACK;
              sda_oe_reg    <= 1'b0;
            end else begin
              shift_reg   <= {shift_reg[6:0], 1'b0};
              sda_oe_reg  <= ~shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  assign sda_out    = 1'b0;
  assign sda_oe_out = sda_oe_reg;

  // ************************************************
  // register file
  // ************************************************
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < `CHAN_COUNT; i++) begin
        setup_reg[i] <= `SETUP_RESET;
      end
      on_bits_reg <= `ON_BITS_RESET;
    end else if (lock_s) begin
      for (int i = 0; i < `CHAN_COUNT; i++) begin
        setup_reg[i] <= `SETUP_RESET;
      end
      on_bits_reg <= `ON_BITS_RESET;
    end else if (wr_stb) begin
      if (is_setup(ptr_reg)) begin
        setup_reg[ptr_reg[2:0]] <= shift_reg[4:0];
      end else if (ptr_reg == `OFS_ON_BITS) begin
        on_bits_reg <= shift_reg[4:0];
      end
    end
  end

  // ************************************************
  // channel requests
  // ************************************************
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      eff_en_reg <= 5'h00;
    end else if (lock_s) begin
      eff_en_reg <= 5'h00;
    end else if (i2cen_s) begin
      eff_en_reg <= on_bits_reg | {4'h0, force_s};
    end
  end

  // one sequencer per channel
  genvar g;
  for (g = 0; g < `CHAN_COUNT; g++) begin : g_chan
    chan_drv_t drv;  // drive signals of this channel
    load_channel_seq #(
      .SS_BASE_CYC (SS_BASE_CYC),
      .DIS_CYC     (DIS_CYC)
    ) u_seq (
      .mclk_in    (mclk_in),
      .rstn_in    (rstn_in),
      .lockout_in (lock_s),
      .chan_on_in (eff_en_reg[g]),
      .cfg_in     (chan_cfg_t'(setup_reg[g])),
      .drv_out    (drv)
    );
    assign main_sw_on_out[g] = drv.main_on;
    assign dischg_on_out[g]  = drv.dischg_on;
    assign ramp_on_out[g]    = drv.ramp_on;
  end

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  AST_ADDR_MISS: assert property (
    byte_end && first_reg && !lock_s && !stop_det && !start_det
    && shift_reg[7:1] != `TARGET_ADDR7
    |=> i2c_state_reg == I2C_IDLE && !sda_oe_out)
    else $error("acknowledged foreign address");
  AST_ADDR_ACK: assert property (
    byte_end && first_reg && !lock_s && i2cen_s
    && shift_reg[7:1] == `TARGET_ADDR7
    |=> i2c_state_reg == I2C_ACK && sda_oe_out)
    else $error("own address not acknowledged");
  AST_ON_RESET: assert property (
    lock_s
    |=> on_bits_reg == `ON_BITS_RESET && setup_reg[0] == `SETUP_RESET)
    else $error("registers not at power-up value");
  AST_CHAN0_OR: assert property (
    i2cen_s && !lock_s && (on_bits_reg[0] || force_s)
    |=> eff_en_reg[0])
    else $error("channel 0 request missing");
  AST_LOCK_PTR: assert property (
    lock_s |=> ptr_reg == 8'h00 && i2c_state_reg == I2C_IDLE)
    else $error("pointer kept through lockout");
  AST_FREEZE: assert property (
    !i2cen_s && !lock_s
    |=> $stable(eff_en_reg) && $stable(on_bits_reg))
    else $error("state changed while disabled");
  AST_SETUP_FREEZE: assert property (
    !i2cen_s && !lock_s |=> $stable(setup_reg[0]) && $stable(setup_reg[4]))
    else $error("setup changed while disabled");
  AST_OFF_NACK: assert property (
    byte_end && first_reg && !i2cen_s |=> !sda_oe_out)
    else $error("address acknowledged while disabled");
  AST_PTR_ADV: assert property (
    wr_stb && ptr_reg != `PTR_MAX
    |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("pointer did not advance");
  AST_PTR_LOAD: assert property (
    byte_end && !first_reg && !rw_reg && !ptr_set_reg && !lock_s
    |=> ptr_set_reg && ptr_reg == $past(shift_reg))
    else $error("pointer byte not taken");
  AST_NO_WRAP: assert property (
    wr_stb && ptr_reg == `PTR_MAX |=> ptr_reg == `PTR_MAX)
    else $error("pointer wrapped");
  COV_WRITE: cover property (wr_stb ##[1:1000] wr_stb);
  COV_READ: cover property (i2c_state_reg == I2C_TX && bit_cnt_reg == 4'h8);
  COV_FORCE: cover property (force_s && !on_bits_reg[0] && eff_en_reg[0]);
endmodule

/* File: load_switch_ctrl_regs_tb_top.sv */
module load_switch_ctrl_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SS  = 20;
  localparam int unsigned DIS = 400;
  logic        mclk = 0, rstn = 0, i2c_en = 1, force0 = 0, lockout = 0;
  wire         scl, h_oe, d_out, d_oe;
  wire  [4:0]  main_on, dis_on, ramp_on;
  // open drain data line with pull-up
  wire         sda = (d_oe ? d_out : 1'b1) & ~h_oe;
  int          err_count, compares, cyc;
  int unsigned rc [5], dc [5];
  logic [4:0]  ramp_d, dis_d;
  logic [7:0]  dq [$];
  logic        ok;
  always #10 mclk = ~mclk;
  load_switch_ctrl_regs #(.SS_BASE_CYC(SS), .DIS_CYC(DIS))
    i_load_switch_ctrl_regs (.mclk_in(mclk), .rstn_in(rstn),
    .scl_in(scl), .sda_in(sda), .sda_out(d_out), .sda_oe_out(d_oe),
    .i2c_enable_in(i2c_en), .chan0_force_pin_in(force0),
    .supply_undervolt_lockout_in(lockout), .main_sw_on_out(main_on),
    .dischg_on_out(dis_on), .ramp_on_out(ramp_on));
  i2c_host_model i_i2c_host_model (.mclk_in(mclk), .sda_in(sda),
    .scl_out(scl), .sda_oe_out(h_oe));
  // pulse length counters, overlap watch, run limit
  always @(posedge mclk) begin
    ramp_d <= ramp_on;
    dis_d  <= dis_on;
    for (int k = 0; k < 5; k++) begin
      if (ramp_on[k]) rc[k] <= ramp_d[k] ? rc[k] + 1 : 1;
      if (dis_on[k]) dc[k] <= dis_d[k] ? dc[k] + 1 : 1;
    end
    if ((main_on & dis_on) !== 5'h00) begin
      err_count++;
      $display("Error overlap expected 00 seen %h", main_on & dis_on);
    end
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [7:0] d [$]);
    i_i2c_host_model.access(a, p, 1'b0, 0, d, ok);
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    dq = {};
    i_i2c_host_model.access(7'h2E, p, 1'b1, n, dq, ok);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  initial begin
    wait_cyc(6);
    rstn <= 1'b1;
    wait_cyc(4);
    // power-up values, burst past the last register
    rd(8'h00, 7);
    chk("ack", 1, ok);
    for (int i = 0; i < 5; i++) chk("setup", 8'h08, dq[i]);
    chk("on_bits", 8'h00, dq[5]);
    chk("past top", 8'h00, dq[6]);
    wr(7'h2F, 8'h05, '{8'h1F});
    chk("bad addr ack", 0, ok);
    // pulse, none, held, ramp x1, ramp x8, all on
    wr(7'h2E, 8'h00, '{8'h08, 8'h00, 8'h18, 8'h0C, 8'h07, 8'h1F});
    chk("wr ack", 1, ok);
    wait_cyc(200);
    chk("main", 5'h1F, main_on);
    chk("ramp3", SS, rc[3]);
    chk("ramp4", SS * 8, rc[4]);
    chk("ramp0", 0, rc[0]);
    // all off, pin brings channel 0 back in mid pulse
    wr(7'h2E, 8'h05, '{8'h00});
    force0 <= 1'b1;
    wait_cyc(20);
    chk("forced", 1, main_on[0]);
    chk("cut pulse", 1, dc[0] < DIS);
    force0 <= 1'b0;
    wait_cyc(DIS + 40);
    chk("pulse0", DIS, dc[0]);
    chk("pulse3", DIS, dc[3]);
    chk("dis", 5'h04, dis_on);
    chk("main off", 5'h00, main_on);
    // bus disabled: commands ignored, switches frozen
    i2c_en <= 1'b0;
    wait_cyc(4);
    force0 <= 1'b1;
    wr(7'h2E, 8'h05, '{8'h02});
    chk("off ack", 0, ok);
    chk("frozen", 5'h00, main_on);
    i2c_en <= 1'b1;
    wait_cyc(20);
    chk("unfrozen", 5'h01, main_on);
    // lockout clears switches and registers
    lockout <= 1'b1;
    wait_cyc(5);
    chk("lock main", 5'h00, main_on);
    chk("lock dis", 5'h00, dis_on);
    lockout <= 1'b0;
    force0 <= 1'b0;
    wait_cyc(4);
    rd(8'h02, 1);
    chk("lock reg", 8'h08, dq[0]);
    // pointer held at the top, then the middle ramp codes
    wr(7'h2E, 8'hFE, '{8'h00, 8'h00, 8'h00});
    chk("top ack", 1, ok);
    wr(7'h2E, 8'h03, '{8'h05, 8'h06, 8'h18});
    wait_cyc(120);
    chk("main x", 5'h18, main_on);
    chk("ramp3 x2", SS * 2, rc[3]);
    chk("ramp4 x4", SS * 4, rc[4]);
    print_verdict();
  end
endmodule

/* File: load_switch_defs.svh */
`ifndef LOAD_SWITCH_DEFS_SVH
`define LOAD_SWITCH_DEFS_SVH
// ************************************************
// clock and timing
// ************************************************
`define CLK_PERIOD_NS 20
// least time in ns rounded up to whole clock cycles
`define CYC_MIN(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SS_BASE_NS 1000000
`define DIS_PULSE_NS 1700000
`define BBM_NS 100
`define OFF_TO_DIS_NS 220
// ************************************************
// target address and register map
// ************************************************
`define TARGET_ADDR7 7'h2E
`define OFS_SETUP_LAST 8'h04
`define OFS_ON_BITS 8'h05
`define PTR_MAX 8'hFF
`define SETUP_RESET 5'h08
`define ON_BITS_RESET 5'h00
`define CHAN_COUNT 5
`endif

/* File: load_switch_pkg.sv */
package load_switch_pkg;
  // ************************************************
  // per-channel setup fields, bit 4 down to bit 0
  // ************************************************
  typedef struct packed {
    logic dischg_hold_type;
    logic dischg_allow;
    logic softstart_use;
    logic softstart_sel_hi;
    logic softstart_sel_lo;
  } chan_cfg_t;
  // drive signals of one channel
  typedef struct packed {
    logic main_on;
    logic dischg_on;
    logic ramp_on;
  } chan_drv_t;
  // channel sequencer states
  typedef enum logic [2:0] {
    CH_OFF     = 3'b000,
    CH_OFF_DLY = 3'b001,
    CH_DIS     = 3'b010,
    CH_BBM     = 3'b011,
    CH_RAMP    = 3'b100,
    CH_ON      = 3'b101
  } chan_state_t;
  // serial target states
  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_RX   = 3'b001,
    I2C_ACK  = 3'b010,
    I2C_TX   = 3'b011,
    I2C_RACK = 3'b100
  } i2c_state_t;
endpackage
